// ### bench/bfsb_host.sv
// host model: byte reads, byte writes and clear-all pulses on the command port
module bfsb_host (
   input  wire logic       clk_i,
   input  wire logic [7:0] rd_data_i,
   input  wire logic       rd_valid_i,
   output logic            valid_o,
   output logic            write_o,
   output logic [7:0]      code_o,
   output logic [7:0]      data_o,
   output logic            clr_o,
   output logic            ro_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial {valid_o, write_o, code_o, data_o, clr_o, ro_o} = '0;

   // ---------------------------------------------
   // transactions, one whole byte each
   // ---------------------------------------------
   // request held across exactly one rising edge, the answer is waited for a bounded time
   task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d, output logic [7:0] q);
      int n = 0;
      q = 8'hxx;
      @(negedge clk_i);
      {valid_o, write_o, code_o, data_o} = {1'h1, w, c, d};
      @(negedge clk_i);
      valid_o = 1'h0;
      while (!w && rd_valid_i !== 1'h1 && n < 3) begin
         @(negedge clk_i);
         n++;
      end
      if (!w && rd_valid_i === 1'h1) q = rd_data_i;
   endtask : xfer

   // k=1 clear-all command, k=0 write to a read-only command
   task automatic pulse(input logic k);
      @(negedge clk_i);
      if (k) clr_o = 1'h1;
      else ro_o = 1'h1;
      @(negedge clk_i);
      {clr_o, ro_o} = '0;
   endtask : pulse
endmodule : bfsb_host

// ### bench/tb.sv
// testbench: random fault events, write-one clears, live bits and alert ownership
`define CHK(a, e, m) begin n_compared++; if ((a) !== (e)) begin error_cnt++; \
   $display("mismatch t=%0t %s got %h exp %h", $time, m, a, e); end end
module tb;
   import bfsb_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk = 1'h0, rst_n = 1'h0, follower = 1'h0, busy = 1'h0, miss = 1'h0, other_n = 1'h1;
   logic        vld, wr, clr, ro, rdv, aout, aoe;
   logic [7:0]  code, din, rdd, q, tmask = 8'hff, cmask = 8'hff, mmask = 8'hff;
   logic [12:0] ev = '0;
   logic [3:0]  summ;
   logic [31:0] seed = 32'h1923, r, w, ex;
   int          error_cnt = 0, n_compared = 0, cyc = 0;
   // open-drain line: we pull low while enabled, another device may pull it too
   wire         bus_n = ~aoe & other_n;

   always #2 clk = ~clk;

   bfsb_host u_host (.clk_i(clk), .rd_data_i(rdd), .rd_valid_i(rdv), .valid_o(vld), .write_o(wr),
      .code_o(code), .data_o(din), .clr_o(clr), .ro_o(ro));

   bfsb_status_bank u_dut (.sys_clk_i(clk), .reset_n_i(rst_n), .cmd_valid_i(vld), .cmd_write_i(wr),
      .cmd_code_i(code), .cmd_data_i(din), .clear_faults_i(clr), .ro_write_i(ro), .rd_data_o(rdd),
      .rd_valid_o(rdv), .overtemp_fault_i(ev[0]), .overtemp_warning_i(ev[1]), .bad_command_i(ev[2]),
      .bad_payload_i(ev[3]), .pec_fail_i(ev[4]), .memory_error_i(ev[5]), .logic_core_error_i(ev[6]),
      .link_error_i(ev[7]), .loop_follower_i(follower), .back_channel_link_fail_i(ev[8]),
      .por_check_bad_i(ev[9]), .self_check_busy_i(busy), .follower_missing_i(miss),
      .vout_reset_i(ev[10]), .back_channel_fault_i(ev[11]), .sync_fault_i(ev[12]),
      .temp_mask_i(tmask), .cml_mask_i(cmask), .mfr_mask_i(mmask), .temp_summary_o(summ[3]),
      .cml_summary_o(summ[2]), .other_summary_o(summ[1]), .mfr_summary_o(summ[0]),
      .alert_bus_n_i(bus_n), .alert_out_o(aout), .alert_oe_o(aoe));

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   function automatic logic [31:0] xorshift();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xorshift

   // expected bytes packed as temperature, link_error_flag, other, maker
   function automatic logic [31:0] expect_all(input logic [12:0] e, input logic f);
      logic [7:0] t, c, m;
      t = {e[0], e[1], 6'h00};
      c = {e[2], e[3], e[4], e[5], e[6], 1'h0, e[7] | (e[8] & f), 1'h0};
      m = {e[9], 3'h0, e[10], e[11], e[12], 1'h0};
      return {t, c, 8'h00, m};
   endfunction : expect_all

   task automatic fire(input logic [12:0] e);
      @(negedge clk);
      ev = e;
      @(negedge clk);
      ev = '0;
   endtask : fire

   task automatic check_all(input logic [31:0] e);
      logic [7:0] b;
      for (int i = 0; i < 4; i++) begin
         u_host.xfer(1'h0, CODE_TEMP + 8'(i), 8'h00, b);
         `CHK(b, e[31-8*i -: 8], "status byte")
      end
      // live maker bit stays out of the maker summary
      `CHK(summ, ({|e[31:24], |e[23:16], |e[15:8], |(e[7:0] & 8'hbf)}), "summary")
   endtask : check_all

   task automatic write_all(input logic [31:0] d);
      for (int i = 0; i < 4; i++) u_host.xfer(1'h1, CODE_TEMP + 8'(i), d[31-8*i -: 8], q);
   endtask : write_all

   task automatic give_verdict();
      $display("compared %0d errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict

   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         give_verdict();
      end
   end

   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      repeat (5) @(negedge clk);
      rst_n = 1'h1;
      repeat (3) @(negedge clk);
      check_all(32'h0);
      u_host.xfer(1'h0, 8'h7c, 8'h00, q);
      `CHK(q, 8'h00, "unlisted read")
      @(negedge clk);
      `CHK(rdv, 1'h0, "read valid width")
      // write to a read-only command, then clear it by write-one
      u_host.pulse(1'h0);
      check_all(32'h00800000);
      u_host.xfer(1'h1, CODE_CML, 8'h80, q);
      check_all(32'h0);
      // event and clear in one cycle: the set wins
      fork
         fire(13'h11);
         u_host.xfer(1'h1, CODE_CML, 8'h20, q);
      join
      check_all(32'h80200000);
      fork
         fire(13'h10);
         u_host.pulse(1'h1);
      join
      check_all(32'h00200000);
      u_host.pulse(1'h1);
      // masks all set here so no alert and no earliest-alerter flag disturb the bytes
      for (int k = 0; k < 40; k++) begin
         r = xorshift();
         ex = expect_all(r[12:0], r[13]);
         follower = r[13];
         fire(r[12:0]);
         check_all(ex);
         w = xorshift();
         write_all(w);
         check_all(ex & ~w);
         write_all(32'h0);
         check_all(ex & ~w);
         u_host.pulse(1'h1);
         check_all(32'h0);
      end
      // live self-check bit ignores writes
      busy = 1'h1;
      check_all(32'h40);
      write_all(32'hffffffff);
      check_all(32'h40);
      busy = 1'h0;
      miss = 1'h1;
      check_all(32'h40);
      miss = 1'h0;
      // masked flag keeps the line released
      fire(13'h1);
      repeat (4) @(negedge clk);
      `CHK(aoe, 1'h0, "masked alert")
      u_host.pulse(1'h1);
      // unmasked flag on an idle line: we are first
      tmask = 8'h7f;
      fire(13'h1);
      repeat (4) @(negedge clk);
      `CHK(aoe, 1'h1, "alert drive")
      `CHK(aout, 1'h0, "alert level")
      check_all(32'h80000100);
      u_host.pulse(1'h1);
      repeat (3) @(negedge clk);
      `CHK(aoe, 1'h0, "alert release")
      check_all(32'h0);
      // another device already holds the line low
      other_n = 1'h0;
      fire(13'h1);
      repeat (4) @(negedge clk);
      check_all(32'h80000000);
      u_host.pulse(1'h1);
      other_n = 1'h1;
      check_all(32'h0);
      // reset in mid-run drops every flag and the alert drive
      fire(13'h1fff);
      @(negedge clk);
      rst_n = 1'h0;
      repeat (3) @(negedge clk);
      `CHK(aoe, 1'h0, "alert in reset")
      rst_n = 1'h1;
      repeat (3) @(negedge clk);
      check_all(32'h0);
      give_verdict();
   end
endmodule : tb

// ### hw/bfsb_alert_ctl.sv
// module: alert pin drive and earliest-alerter detection
module bfsb_alert_ctl
   import bfsb_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic req_i,
   input  wire logic bus_n_i,
   output logic      first_o,
   output logic      idle_o,
   output logic      oe_o
);

   typedef struct packed {
      logic oe;
   } bfsb_alert_st_t;

   bfsb_alert_st_t st;
   bfsb_alert_st_t next_st;

   always_comb begin
      next_st    = st;
      next_st.oe = req_i;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // we start driving while nobody else holds the line low
   assign first_o = req_i & ~st.oe & bus_n_i;
   // line released and we have nothing to say: flag no longer true
   assign idle_o  = bus_n_i & ~req_i & ~st.oe;
   assign oe_o    = st.oe;

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_first_needs_idle: assert property (first_o |-> (bus_n_i && !oe_o))
      else $error("first flag raised while line already low");
   chk_drive_follows: assert property (req_i |=> oe_o)
      else $error("alert request not driven");

endmodule : bfsb_alert_ctl

// ### hw/bfsb_flag_if.sv
// interface: set, write-one-clear and flag lines of one status byte
interface bfsb_flag_if;
   logic [7:0] set;
   logic [7:0] w1c;
   logic       clr_all;
   logic [7:0] flags;
   modport owner (input set, input w1c, input clr_all, output flags);
   modport user  (output set, output w1c, output clr_all, input flags);
endinterface : bfsb_flag_if

// ### hw/bfsb_flag_latch.sv
// module: one byte of sticky status flags with write-one-clear
module bfsb_flag_latch
   import bfsb_pkg::*;
#(
   parameter logic [7:0] KEEP = 8'hff
)(
   input wire logic  clk_i,
   input wire logic  rst_n_i,
   bfsb_flag_if.owner fl
);

   typedef struct packed {
      logic [7:0] flags;
   } bfsb_latch_st_t;

   bfsb_latch_st_t st;
   bfsb_latch_st_t next_st;
   logic [7:0]     set_k;

   assign set_k = fl.set & KEEP;

   // -------------------------------------------------
   // next state: a set in the clearing cycle wins
   // -------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.flags = st.flags & ~fl.w1c;
      if (fl.clr_all) begin
         next_st.flags = STATUS_RST;
      end
      next_st.flags = (next_st.flags | set_k) & KEEP;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign fl.flags = st.flags;

   // -------------------------------------------------
   // checks
   // -------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   chk_set_sticks: assert property (|set_k |=> ((fl.flags & $past(set_k)) == $past(set_k)))
      else $error("flag set was lost");
   chk_unused_zero: assert property ((fl.flags & ~KEEP) == 8'h00)
      else $error("unsupported flag bit reads one");
   chk_zero_keeps: assert property ((fl.set == 8'h00 && fl.w1c == 8'h00 && !fl.clr_all)
                                    |=> $stable(fl.flags))
      else $error("flag changed without cause");

endmodule : bfsb_flag_latch

// ### hw/bfsb_pkg.sv
// package: command codes, flag positions and masks of the status flag bank
package bfsb_pkg;

   // -------------------------------------------------
   // command codes of the four status bytes
   // -------------------------------------------------
   localparam logic [7:0] CODE_TEMP  = 8'h7d;
   localparam logic [7:0] CODE_CML   = 8'h7e;
   localparam logic [7:0] CODE_OTHER = 8'h7f;
   localparam logic [7:0] CODE_MFR   = 8'h80;

   // -------------------------------------------------
   // flag positions
   // -------------------------------------------------
   localparam int unsigned TEMP_FAULT_BIT  = 7;
   localparam int unsigned TEMP_WARN_BIT   = 6;
   localparam int unsigned CML_BADCMD_BIT  = 7;
   localparam int unsigned CML_BADDATA_BIT = 6;
   localparam int unsigned CML_PEC_BIT     = 5;
   localparam int unsigned CML_MEMERR_BIT  = 4;
   localparam int unsigned CML_CORE_BIT    = 3;
   localparam int unsigned CML_LINK_BIT    = 1;
   localparam int unsigned OTHER_FIRST_BIT = 0;
   localparam int unsigned MFR_POR_BIT     = 7;
   localparam int unsigned MFR_SELF_BIT    = 6;
   localparam int unsigned MFR_VRESET_BIT  = 3;
   localparam int unsigned MFR_BACKCH_BIT  = 2;
   localparam int unsigned MFR_SYNC_BIT    = 1;

   // -------------------------------------------------
   // latched bits per byte, reset value
   // -------------------------------------------------
   localparam logic [7:0] TEMP_LATCH  = 8'hc0;
   localparam logic [7:0] CML_LATCH   = 8'hfa;
   localparam logic [7:0] OTHER_LATCH = 8'h01;
   localparam logic [7:0] MFR_LATCH   = 8'h8e;
   localparam logic [7:0] STATUS_RST  = 8'h00;

   // one-hot byte for a flag position
   function automatic logic [7:0] bfsb_bit(input int unsigned pos, input logic on);
      bfsb_bit = on ? (8'h01 << pos[2:0]) : 8'h00;
   endfunction : bfsb_bit

endpackage : bfsb_pkg

// ### hw/bfsb_status_bank.sv
// module: top of the status flag bank with byte command port
// ------------------------------------------------------------
module bfsb_status_bank
   import bfsb_pkg::*;
(
   input  wire logic       sys_clk_i,
   input  wire logic       reset_n_i,
   // host byte command port
   input  wire logic       cmd_valid_i,
   input  wire logic       cmd_write_i,
   input  wire logic [7:0] cmd_code_i,
   input  wire logic [7:0] cmd_data_i,
   input  wire logic       clear_faults_i,
   input  wire logic       ro_write_i,
   output logic [7:0]      rd_data_o,
   output logic            rd_valid_o,
   // fault events
   input  wire logic       overtemp_fault_i,
   input  wire logic       overtemp_warning_i,
   input  wire logic       bad_command_i,
   input  wire logic       bad_payload_i,
   input  wire logic       pec_fail_i,
   input  wire logic       memory_error_i,
   input  wire logic       logic_core_error_i,
   input  wire logic       link_error_i,
   input  wire logic       loop_follower_i,
   input  wire logic       back_channel_link_fail_i,
   input  wire logic       por_check_bad_i,
   input  wire logic       self_check_busy_i,
   input  wire logic       follower_missing_i,
   input  wire logic       vout_reset_i,
   input  wire logic       back_channel_fault_i,
   input  wire logic       sync_fault_i,
   // alert masks, one bit per flag position
   input  wire logic [7:0] temp_mask_i,
   input  wire logic [7:0] cml_mask_i,
   input  wire logic [7:0] mfr_mask_i,
   // summary bits toward the top-level status byte
   output logic            temp_summary_o,
   output logic            cml_summary_o,
   output logic            other_summary_o,
   output logic            mfr_summary_o,
   // open-drain alert line
   input  wire logic       alert_bus_n_i,
   output logic            alert_out_o,
   output logic            alert_oe_o
);

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   logic rst_meta;
   logic rst_n;

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] rd_data;
      logic       rd_valid;
   } bfsb_top_st_t;

   bfsb_top_st_t st;
   bfsb_top_st_t next_st;

   bfsb_flag_if temp_if ();
   bfsb_flag_if cml_if ();
   bfsb_flag_if other_if ();
   bfsb_flag_if mfr_if ();

   logic       host_wr;
   logic       host_rd;
   logic [7:0] temp_view;
   logic [7:0] cml_view;
   logic [7:0] other_view;
   logic [7:0] mfr_view;
   logic       alert_req;
   logic       first_evt;
   logic       line_idle;

   assign host_wr = cmd_valid_i & cmd_write_i;
   assign host_rd = cmd_valid_i & ~cmd_write_i;

   // ------------------------------------------------------------
   // event sets
   // ------------------------------------------------------------
   assign temp_if.set = bfsb_bit(TEMP_FAULT_BIT, overtemp_fault_i)
                      | bfsb_bit(TEMP_WARN_BIT, overtemp_warning_i);

   assign cml_if.set  = bfsb_bit(CML_BADCMD_BIT, bad_command_i | ro_write_i)
                      | bfsb_bit(CML_BADDATA_BIT, bad_payload_i)
                      | bfsb_bit(CML_PEC_BIT, pec_fail_i)
                      | bfsb_bit(CML_MEMERR_BIT, memory_error_i)
                      | bfsb_bit(CML_CORE_BIT, logic_core_error_i)
                      | bfsb_bit(CML_LINK_BIT, link_error_i
                                 | (loop_follower_i & back_channel_link_fail_i));

   assign other_if.set = bfsb_bit(OTHER_FIRST_BIT, first_evt);

   assign mfr_if.set  = bfsb_bit(MFR_POR_BIT, por_check_bad_i)
                      | bfsb_bit(MFR_VRESET_BIT, vout_reset_i)
                      | bfsb_bit(MFR_BACKCH_BIT, back_channel_fault_i)
                      | bfsb_bit(MFR_SYNC_BIT, sync_fault_i);

   // ------------------------------------------------------------
   // host clears: whole-byte write, ones clear, zeros keep
   // ------------------------------------------------------------
   assign temp_if.w1c  = (host_wr && cmd_code_i == CODE_TEMP) ? cmd_data_i : 8'h00;
   assign cml_if.w1c   = (host_wr && cmd_code_i == CODE_CML) ? cmd_data_i : 8'h00;
   // earliest flag also drops once the line is idle and we are silent
   assign other_if.w1c = ((host_wr && cmd_code_i == CODE_OTHER) ? cmd_data_i : 8'h00)
                       | bfsb_bit(OTHER_FIRST_BIT, line_idle);
   assign mfr_if.w1c   = (host_wr && cmd_code_i == CODE_MFR) ? cmd_data_i : 8'h00;

   assign temp_if.clr_all  = clear_faults_i;
   assign cml_if.clr_all   = clear_faults_i;
   assign other_if.clr_all = clear_faults_i;
   assign mfr_if.clr_all   = clear_faults_i;

   // ------------------------------------------------------------
   // flag bytes
   // ------------------------------------------------------------
   bfsb_flag_latch #(.KEEP(TEMP_LATCH)) u_temp (
      .clk_i   (sys_clk_i),
      .rst_n_i (rst_n),
      .fl      (temp_if)
   );

   bfsb_flag_latch #(.KEEP(CML_LATCH)) u_cml (
      .clk_i   (sys_clk_i),
      .rst_n_i (rst_n),
      .fl      (cml_if)
   );

   bfsb_flag_latch #(.KEEP(OTHER_LATCH)) u_other (
      .clk_i   (sys_clk_i),
      .rst_n_i (rst_n),
      .fl      (other_if)
   );

   bfsb_flag_latch #(.KEEP(MFR_LATCH)) u_mfr (
      .clk_i   (sys_clk_i),
      .rst_n_i (rst_n),
      .fl      (mfr_if)
   );

   // ------------------------------------------------------------
   // read views and summaries
   // ------------------------------------------------------------
   assign temp_view  = temp_if.flags;
   assign cml_view   = cml_if.flags;
   assign other_view = other_if.flags;
   // live bit bypasses the latch so it can never be cleared by software
   assign mfr_view   = mfr_if.flags
                     | bfsb_bit(MFR_SELF_BIT, self_check_busy_i | follower_missing_i);

   // combinational so the summary moves with the flag, not a cycle later
   assign temp_summary_o  = |temp_view;
   assign cml_summary_o   = |cml_view;
   assign other_summary_o = |other_view;
   assign mfr_summary_o   = |mfr_if.flags;

   // ------------------------------------------------------------
   // alert: earliest flag is left out, it would hold itself up
   // ------------------------------------------------------------
   assign alert_req = |(temp_view & ~temp_mask_i)
                    | |(cml_view & ~cml_mask_i)
                    | |(mfr_if.flags & ~mfr_mask_i);

   bfsb_alert_ctl u_alert (
      .clk_i   (sys_clk_i),
      .rst_n_i (rst_n),
      .req_i   (alert_req),
      .bus_n_i (alert_bus_n_i),
      .first_o (first_evt),
      .idle_o  (line_idle),
      .oe_o    (alert_oe_o)
   );

   assign alert_out_o = 1'b0;

   // ------------------------------------------------------------
   // read byte answer, one cycle after the request
   // ------------------------------------------------------------
   always_comb begin
      next_st          = st;
      next_st.rd_valid = host_rd;
      if (host_rd) begin
         if (cmd_code_i == CODE_TEMP) begin
            next_st.rd_data = temp_view;
         end else if (cmd_code_i == CODE_CML) begin
            next_st.rd_data = cml_view;
         end else if (cmd_code_i == CODE_OTHER) begin
            next_st.rd_data = other_view;
         end else if (cmd_code_i == CODE_MFR) begin
            next_st.rd_data = mfr_view;
         end else begin
            next_st.rd_data = 8'h00;
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rd_data_o  = st.rd_data;
   assign rd_valid_o = st.rd_valid;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_n);

   chk_temp_fault: assert property (overtemp_fault_i |=> temp_view[TEMP_FAULT_BIT])
      else $error("temperature fault not latched");
   chk_temp_unused: assert property (temp_view[5:0] == 6'h00)
      else $error("temperature unused bits set");
   chk_pec_latch: assert property (pec_fail_i |=> cml_view[CML_PEC_BIT] && cml_summary_o)
      else $error("pec failure not latched");
   chk_cml_unused: assert property (cml_view[2] == 1'b0 && cml_view[0] == 1'b0)
      else $error("link_error_flag unused bits set");
   chk_follower_link: assert property (loop_follower_i && back_channel_link_fail_i
                                       |=> cml_view[CML_LINK_BIT])
      else $error("follower link failure not reported");
   chk_cml_summary: assert property (cml_if.set != 8'h00 |=> cml_summary_o)
      else $error("link_error_flag summary late");
   chk_w1c_summary: assert property (host_wr && cmd_code_i == CODE_CML && cmd_data_i == 8'hff
                                     && cml_if.set == 8'h00 && !clear_faults_i
                                     |=> !cml_summary_o)
      else $error("link_error_flag summary survived full clear");
   chk_other_reserved: assert property (other_view[7:1] == 7'h00)
      else $error("other reserved bits set");
   chk_self_live: assert property (self_check_busy_i |-> mfr_view[MFR_SELF_BIT])
      else $error("self-check bit not live");
   chk_vreset_latch: assert property (vout_reset_i |=> mfr_view[MFR_VRESET_BIT])
      else $error("output reset event not latched");
   chk_mfr_unused: assert property (mfr_if.flags[5:4] == 2'b00 && mfr_if.flags[0] == 1'b0)
      else $error("maker unused bits set");
   chk_mask_blocks: assert property (temp_mask_i == 8'hff && cml_mask_i == 8'hff
                                     && mfr_mask_i == 8'hff |=> !alert_oe_o)
      else $error("masked flags drove the alert");
   chk_read_answer: assert property (host_rd && cmd_code_i == CODE_CML
                                     |=> rd_valid_o && rd_data_o == $past(cml_view))
      else $error("read byte answer wrong");
   chk_ro_write: assert property (ro_write_i |=> cml_view[CML_BADCMD_BIT] ##0 cml_summary_o)
      else $error("read-only write not flagged");
   chk_clear_all: assert property (clear_faults_i && temp_if.set == 8'h00
                                   |=> temp_view == 8'h00)
      else $error("clear-all left a temperature flag");

   cov_fault_alert: cover property (overtemp_fault_i ##[1:3] alert_oe_o);
   cov_first_alert: cover property (first_evt ##1 other_view[OTHER_FIRST_BIT]);
   cov_w1c_clear:   cover property (cml_summary_o ##1 host_wr ##1 !cml_summary_o);
   cov_ro_write:    cover property (ro_write_i ##1 cml_summary_o);

endmodule : bfsb_status_bank
